// ==== verilog/sholdc_config_bank.sv ====
// configuration bank for alignment, lock/holdover pins and reference inputs.
// assumes lock flags come from logic on the core clock; all pins are asynchronous.
`timescale 1ns/1ns
module sholdc_config_bank (
   input  wire logic                    core_clk_i,
   input  wire logic                    sys_rst_i,
   input  wire logic                    ser_clk_i,
   input  wire logic                    ser_data_i,
   input  wire logic                    ser_latch_i,
   input  wire logic [2:0]              ref_clk_i,
   input  wire logic                    loop1_lock_i,
   input  wire logic                    loop2_lock_i,
   input  wire logic                    sync_pin_i,
   input  wire logic                    status_pin0_i,
   input  wire logic                    status_pin1_i,
   output sholdc_pkg::sholdc_cfg_t      cfg_o,
   output logic                         align_enable_o,
   output logic                         align_hold_o,
   output logic                         align_start_o,
   output logic                         holdover_active_o,
   output logic [2:0]                   signal_loss_o,
   output logic [1:0]                   ref_select_o,
   output logic                         sync_pin_o,
   output logic                         sync_pin_oe_n_o,
   output logic                         lock_pin_o,
   output logic                         lock_pin_oe_n_o,
   output logic                         holdover_pin_o,
   output logic                         holdover_pin_oe_n_o,
   output logic                         status_pin0_o,
   output logic                         status_pin0_oe_n_o,
   output logic                         status_pin1_o,
   output logic                         status_pin1_oe_n_o
);
   logic        wr_valid;
   logic [31:0] wr_word;
   logic [4:0]  wr_addr;
   logic        rd_bit;
   logic [31:0] rd_word;
   logic [4:0]  rd_addr_q;
   logic [31:0] sync_cfg_q;
   logic [31:0] lock_cfg_q;
   logic [31:0] hold_cfg_q;
   logic [31:0] los_cfg_q;
   logic [2:0]  pin_s1_q;
   logic [2:0]  pin_s2_q;
   logic        sync_in_q;
   logic        loop1_lock_q;
   logic        holdover_q;
   logic        align_start_q;
   logic        sync_req;
   logic        loop1_fall;
   logic [2:0]  los_en;

   assign wr_addr = wr_word[4:0];

   sholdc_serial_rx u_rx (
      .core_clk_i  (core_clk_i),
      .sys_rst_i   (sys_rst_i),
      .ser_clk_i   (ser_clk_i),
      .ser_data_i  (ser_data_i),
      .ser_latch_i (ser_latch_i),
      .rd_word_i   (rd_word),
      .wr_valid_o  (wr_valid),
      .wr_word_o   (wr_word),
      .rd_bit_o    (rd_bit)
   );

   assign los_en = {3{los_cfg_q[sholdc_pkg::LOS_EN_BIT]}}
                 & hold_cfg_q[sholdc_pkg::USABLE_LSB +: 3];

   sholdc_los_detect u_los (
      .core_clk_i    (core_clk_i),
      .sys_rst_i     (sys_rst_i),
      .ref_clk_i     (ref_clk_i),
      .enable_i      (los_en),
      .timeout_sel_i (los_cfg_q[sholdc_pkg::LOS_TO_LSB +: 2]),
      .los_o         (signal_loss_o)
   );

   // ---- register bank; writes elsewhere in the map are not stored here

   // alignment word with its reset pattern
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         sync_cfg_q <= sholdc_pkg::RST_SYNC;
      else if (wr_valid && wr_addr == sholdc_pkg::ADDR_SYNC)
         sync_cfg_q <= wr_word;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         lock_cfg_q <= sholdc_pkg::RST_LOCK;
      else if (wr_valid && wr_addr == sholdc_pkg::ADDR_LOCK)
         lock_cfg_q <= wr_word;
   end

   // holdover pin and input select word
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         hold_cfg_q <= sholdc_pkg::RST_HOLD;
      else if (wr_valid && wr_addr == sholdc_pkg::ADDR_HOLD)
         hold_cfg_q <= wr_word;
   end

   // loss detect word, detection on at reset
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         los_cfg_q <= sholdc_pkg::RST_LOS;
      else if (wr_valid && wr_addr == sholdc_pkg::ADDR_LOS)
         los_cfg_q <= wr_word;
   end

   // readback follows the last address written
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         rd_addr_q <= sholdc_pkg::ADDR_SYNC;
      else if (wr_valid)
         rd_addr_q <= wr_addr;
   end

   always_comb
   begin
      unique case (rd_addr_q)
         sholdc_pkg::ADDR_SYNC: rd_word = sync_cfg_q;
         sholdc_pkg::ADDR_LOCK: rd_word = lock_cfg_q;
         sholdc_pkg::ADDR_HOLD: rd_word = hold_cfg_q;
         sholdc_pkg::ADDR_LOS:  rd_word = los_cfg_q;
         default:               rd_word = 32'h0000_0000;
      endcase
   end

   // ---- configuration fields to the rest of the device

   assign cfg_o.exclude_from_align    = sync_cfg_q[sholdc_pkg::EXCL_LSB +: 6];
   assign cfg_o.align_qualify         = sync_cfg_q[sholdc_pkg::QUAL_BIT];
   assign cfg_o.crystal_osc_enable    = sync_cfg_q[sholdc_pkg::XTAL_BIT];
   assign cfg_o.holdover_track_enable = lock_cfg_q[sholdc_pkg::TRACK_BIT];
   assign cfg_o.holdover_mode         = lock_cfg_q[sholdc_pkg::HMODE_LSB +: 2];
   assign cfg_o.reference_select_mode = hold_cfg_q[sholdc_pkg::REFSEL_LSB +: 3];
   assign cfg_o.ref_input_usable      = hold_cfg_q[sholdc_pkg::USABLE_LSB +: 3];

   assign align_enable_o = sync_cfg_q[sholdc_pkg::ALIGN_EN_BIT];

   // ---- pin input synchronisers: sync, status 0, status 1
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         pin_s1_q  <= 3'h0;
         pin_s2_q  <= 3'h0;
         // counts as already seen, so the idle pin gives no start after reset
         sync_in_q <= 1'b1;
      end
      else
      begin
         pin_s1_q  <= {status_pin1_i, status_pin0_i, sync_pin_i};
         pin_s2_q  <= pin_s1_q;
         sync_in_q <= sync_req;
      end
   end

   // polarity bit set means active low
   assign sync_req = sync_cfg_q[sholdc_pkg::POL_BIT] ? ~pin_s2_q[0] : pin_s2_q[0];

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         ref_select_o <= 2'h0;
      else
         ref_select_o <= pin_s2_q[2:1] ^ {2{hold_cfg_q[sholdc_pkg::SELINV_BIT]}};
   end

   // ---- alignment control

   // hold outputs until loop 2 lock
   // hold outputs until loop 1 lock
   assign align_hold_o = align_enable_o
                       & ((lock_cfg_q[sholdc_pkg::HOLD2_BIT] & ~loop2_lock_i)
                        | (lock_cfg_q[sholdc_pkg::HOLD1_BIT] & ~loop1_lock_i));

   // output-register writes start alignment only in automatic mode
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         align_start_q <= 1'b0;
      else
         align_start_q <= align_enable_o
                        & ((wr_valid & (wr_addr <= sholdc_pkg::ADDR_LAST_OUTPUT)
                            & sync_cfg_q[sholdc_pkg::AUTO_BIT])
                         | (sync_pin_oe_n_o & sync_req & ~sync_in_q));
   end

   assign align_start_o = align_start_q;

   // ---- holdover entry
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         loop1_lock_q <= 1'b0;
      else
         loop1_lock_q <= loop1_lock_i;
   end

   assign loop1_fall = loop1_lock_q & ~loop1_lock_i & ~hold_cfg_q[sholdc_pkg::IGNORE_BIT];

   // entry wins over exit in the same cycle
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         holdover_q <= 1'b0;
      // automatic entry only in mode 2
      else if (loop1_fall && cfg_o.holdover_mode == sholdc_pkg::HMODE_AUTO)
         holdover_q <= 1'b1;
      else if (loop1_lock_i || cfg_o.holdover_mode != sholdc_pkg::HMODE_AUTO)
         holdover_q <= 1'b0;
   end

   assign holdover_active_o = holdover_q;

   // ---- status pin multiplexers
   // shared source table; codes above 7 read as low
   function automatic logic pick_source(input logic [4:0] code);
      logic v;
      v = 1'b0;
      unique case (code)
         5'h01:   v = loop1_lock_i;
         5'h02:   v = loop2_lock_i;
         5'h03:   v = loop1_lock_i & loop2_lock_i;
         5'h04:   v = holdover_q;
         5'h05:   v = |signal_loss_o;
         5'h06:   v = align_hold_o;
         5'h07:   v = rd_bit;
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   // oe low drives the pin; only the output type drives
   function automatic logic pin_oe_n(input logic [2:0] pin_type);
      return pin_type != sholdc_pkg::PIN_TYPE_OUT;
   endfunction

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         lock_pin_o     <= 1'b0;
         holdover_pin_o <= 1'b0;
         status_pin0_o  <= 1'b0;
         status_pin1_o  <= 1'b0;
         sync_pin_o     <= 1'b0;
      end
      else
      begin
         lock_pin_o     <= pick_source(lock_cfg_q[sholdc_pkg::LOCK_SRC_LSB +: 5]);
         holdover_pin_o <= pick_source(hold_cfg_q[sholdc_pkg::HPIN_SRC_LSB +: 5]);
         status_pin0_o  <= pick_source({2'h0, hold_cfg_q[sholdc_pkg::ST0_SRC_LSB +: 3]});
         status_pin1_o  <= pick_source({2'h0, hold_cfg_q[sholdc_pkg::ST1_SRC_LSB +: 3]});
         sync_pin_o     <= pick_source({3'h0, sync_cfg_q[sholdc_pkg::SYNC_SRC_LSB +: 2]});
      end
   end

   assign holdover_pin_oe_n_o = pin_oe_n(hold_cfg_q[sholdc_pkg::HPIN_TYPE_LSB +: 3]);
   assign status_pin0_oe_n_o  = pin_oe_n(hold_cfg_q[sholdc_pkg::ST0_TYPE_LSB +: 3]);
   assign status_pin1_oe_n_o  = pin_oe_n(los_cfg_q[sholdc_pkg::ST1_TYPE_LSB +: 3]);
   assign lock_pin_oe_n_o     = pin_oe_n(lock_cfg_q[sholdc_pkg::LOCK_TYPE_LSB +: 3]);
   assign sync_pin_oe_n_o     = pin_oe_n(sync_cfg_q[sholdc_pkg::SYNC_TYPE_LSB +: 3]);
endmodule // sholdc_config_bank

// ==== shared/sholdc_pkg.sv ====
// How it works
// - align enable bit 26, per-output exclusion bits
// - sync pin output source, bits 19:18
// - align qualify by clock output, bit 17
// - sync pin input polarity, reset active low
// - output register writes start alignment only when automatic
// - crystal oscillator enable bit 5, reset off
// - lock pin source bits 31:27, reset 3
// - hold alignment until loop 2 locks
// - hold alignment until loop 1 locks
// - holdover tracking enable bit 8, reset on
// - holdover mode bits 7:6, code 2 automatic
// - holdover pin type and source fields
// - status pin sources, reset constant low
// - status pin 0 type, reset pull-down input
// - optionally ignore loop 1 unlock edge
// - reference select mode bits 11:9, reset 3
// - invert status pins used as selects
// - reference usable flags bits 7:5
// - loss of signal timeout, code 0 1200 ns
// - loss of signal detect enable bit 28
// constants and carrier types of the configuration bank.
// assumes a 50 MHz core clock and a 32-bit serial word, address in bits 4:0.
package sholdc_pkg;
   localparam int          CLK_PERIOD_NS    = 20;
   localparam logic [4:0]  ADDR_SYNC        = 5'h0b;
   localparam logic [4:0]  ADDR_LOCK        = 5'h0c;
   localparam logic [4:0]  ADDR_HOLD        = 5'h0d;
   localparam logic [4:0]  ADDR_LOS         = 5'h0e;
   localparam logic [4:0]  ADDR_LAST_OUTPUT = 5'h05;
   localparam logic [31:0] RST_SYNC         = 32'h0581_100b;
   localparam logic [31:0] RST_LOCK         = 32'h1b00_018c;
   localparam logic [31:0] RST_HOLD         = 32'h3b02_06ed;
   localparam logic [31:0] RST_LOS          = 32'h1200_000e;
   localparam int ALIGN_EN_BIT   = 26;
   localparam int EXCL_LSB       = 20;
   localparam int SYNC_SRC_LSB   = 18;
   localparam int QUAL_BIT       = 17;
   localparam int POL_BIT        = 16;
   localparam int AUTO_BIT       = 15;
   localparam int SYNC_TYPE_LSB  = 12;
   localparam int XTAL_BIT       = 5;
   localparam int LOCK_SRC_LSB   = 27;
   localparam int LOCK_TYPE_LSB  = 24;
   localparam int HOLD2_BIT      = 23;
   localparam int HOLD1_BIT      = 22;
   localparam int TRACK_BIT      = 8;
   localparam int HMODE_LSB      = 6;
   localparam int HPIN_SRC_LSB   = 27;
   localparam int HPIN_TYPE_LSB  = 24;
   localparam int ST1_SRC_LSB    = 20;
   localparam int ST0_TYPE_LSB   = 16;
   localparam int IGNORE_BIT     = 15;
   localparam int ST0_SRC_LSB    = 12;
   localparam int REFSEL_LSB     = 9;
   localparam int SELINV_BIT     = 8;
   localparam int USABLE_LSB     = 5;
   localparam int LOS_TO_LSB     = 30;
   localparam int LOS_EN_BIT     = 28;
   localparam int ST1_TYPE_LSB   = 24;
   localparam logic [1:0] HMODE_AUTO   = 2'h2;
   localparam logic [2:0] PIN_TYPE_OUT = 3'h3;
   localparam int LOS_TO0_NS = 1200;
   localparam int LOS_TO1_NS = 2400;
   localparam int LOS_TO2_NS = 4800;
   localparam int LOS_TO3_NS = 9600;
   localparam int LOS_CNT_W  = 12;
   localparam logic [LOS_CNT_W-1:0] LOS_CNT0 = LOS_CNT_W'((LOS_TO0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [LOS_CNT_W-1:0] LOS_CNT1 = LOS_CNT_W'((LOS_TO1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [LOS_CNT_W-1:0] LOS_CNT2 = LOS_CNT_W'((LOS_TO2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [LOS_CNT_W-1:0] LOS_CNT3 = LOS_CNT_W'((LOS_TO3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef struct packed {
      logic       crystal_osc_enable;
      logic       align_qualify;
      logic [5:0] exclude_from_align;
      logic       holdover_track_enable;
      logic [1:0] holdover_mode;
      logic [2:0] reference_select_mode;
      logic [2:0] ref_input_usable;
   } sholdc_cfg_t;
endpackage

// ==== verilog/sholdc_serial_rx.sv ====
// serial programming port receiver with readback shifter.
// assumes serial clock, data and latch are asynchronous pins, much slower than the core clock.
`timescale 1ns/1ns
module sholdc_serial_rx (
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ser_clk_i,
   input  wire logic        ser_data_i,
   input  wire logic        ser_latch_i,
   input  wire logic [31:0] rd_word_i,
   output logic             wr_valid_o,
   output logic [31:0]      wr_word_o,
   output logic             rd_bit_o
);
   logic [2:0]  clk_s_q;
   logic [1:0]  data_s_q;
   logic [2:0]  le_s_q;
   logic [31:0] shift_q;
   logic [31:0] rd_shift_q;
   logic        load_q;
   logic        ser_rise;
   logic        latch_rise;

   assign ser_rise   = clk_s_q[1] & ~clk_s_q[2];
   assign latch_rise = le_s_q[1] & ~le_s_q[2];
   assign rd_bit_o   = rd_shift_q[31];

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         clk_s_q  <= 3'h0;
         data_s_q <= 2'h0;
         le_s_q   <= 3'h0;
      end
      else
      begin
         clk_s_q  <= {clk_s_q[1:0], ser_clk_i};
         data_s_q <= {data_s_q[0], ser_data_i};
         le_s_q   <= {le_s_q[1:0], ser_latch_i};
      end
   end

   // msb first; the last 32 bits before latch form the word
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         shift_q <= 32'h0000_0000;
      else if (ser_rise)
         shift_q <= {shift_q[30:0], data_s_q[1]};
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         wr_valid_o <= 1'b0;
         wr_word_o  <= 32'h0000_0000;
      end
      else
      begin
         wr_valid_o <= latch_rise;
         if (latch_rise)
            wr_word_o <= shift_q;
      end
   end

   // reload two cycles after latch so the bank already holds the new value
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         load_q     <= 1'b0;
         rd_shift_q <= 32'h0000_0000;
      end
      else
      begin
         load_q <= wr_valid_o;
         if (load_q)
            rd_shift_q <= rd_word_i;
         else if (ser_rise)
            rd_shift_q <= {rd_shift_q[30:0], 1'b0};
      end
   end
endmodule // sholdc_serial_rx

// ==== verilog/sholdc_los_detect.sv ====
// loss of signal detection for the three reference inputs.
// assumes reference clocks are pins far slower than the core clock, so every toggle is seen.
`timescale 1ns/1ns
module sholdc_los_detect (
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [2:0] ref_clk_i,
   input  wire logic [2:0] enable_i,
   input  wire logic [1:0] timeout_sel_i,
   output logic      [2:0] los_o
);
   logic [sholdc_pkg::LOS_CNT_W-1:0] limit;

   always_comb
   begin
      unique case (timeout_sel_i)
         2'h0: limit = sholdc_pkg::LOS_CNT0;
         2'h1: limit = sholdc_pkg::LOS_CNT1;
         2'h2: limit = sholdc_pkg::LOS_CNT2;
         2'h3: limit = sholdc_pkg::LOS_CNT3;
      endcase
   end

   for (genvar g = 0; g < 3; g++)
   begin : g_ref
      logic [2:0]                       s_q;
      logic [sholdc_pkg::LOS_CNT_W-1:0] cnt_q;
      always_ff @(posedge core_clk_i)
      begin
         if (sys_rst_i)
         begin
            s_q      <= 3'h0;
            cnt_q    <= '0;
            los_o[g] <= 1'b0;
         end
         else
         begin
            s_q <= {s_q[1:0], ref_clk_i[g]};
            if (!enable_i[g] || (s_q[1] != s_q[2]))
            begin
               cnt_q    <= '0;
               los_o[g] <= 1'b0;
            end
            else if (cnt_q >= limit - 1'b1)
               los_o[g] <= 1'b1;
            else
               cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule // sholdc_los_detect

// ==== tb/sholdc_host_model.sv ====
// host side of the serial programming port: shifts 32-bit words and latches them.
// assumes the bank samples the pins on its core clock; pins change on falling edges.
`timescale 1ns/1ns
module sholdc_host_model (
   input  wire logic core_clk_i,
   output logic      ser_clk_o,
   output logic      ser_data_o,
   output logic      ser_latch_o
);
   initial
   begin
      ser_clk_o   = 1'b0;
      ser_data_o  = 1'b0;
      ser_latch_o = 1'b0;
   end

   // three core cycles high and four low per serial bit, the fastest the bank is promised
   task automatic write_word(input logic [31:0] word);
      for (int i = 31; i >= 0; i--)
      begin
         @(negedge core_clk_i);
         ser_data_o = word[i];
         repeat (3) @(negedge core_clk_i);
         ser_clk_o = 1'b1;
         repeat (3) @(negedge core_clk_i);
         ser_clk_o = 1'b0;
      end
      @(negedge core_clk_i);
      ser_latch_o = 1'b1;
      ser_data_o  = ~word[0];
      repeat (3) @(negedge core_clk_i);
      ser_latch_o = 1'b0;
      repeat (3) @(negedge core_clk_i);
   endtask
endmodule // sholdc_host_model

// ==== tb/sholdc_config_bank_checker.sv ====
// port assertions for the configuration bank.
// assumes one core clock domain with synchronous active-high reset.
`timescale 1ns/1ns
module sholdc_config_bank_checker (
   input wire logic                    core_clk_i,
   input wire logic                    sys_rst_i,
   input wire logic [2:0]              ref_clk_i,
   input wire logic                    loop1_lock_i,
   input wire logic                    loop2_lock_i,
   input wire sholdc_pkg::sholdc_cfg_t cfg_o,
   input wire logic                    align_enable_o,
   input wire logic                    align_hold_o,
   input wire logic                    align_start_o,
   input wire logic                    holdover_active_o,
   input wire logic [2:0]              signal_loss_o,
   input wire logic                    sync_pin_oe_n_o,
   input wire logic                    lock_pin_oe_n_o,
   input wire logic                    holdover_pin_oe_n_o,
   input wire logic                    status_pin0_oe_n_o
);
   logic [7:0] quiet_q;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   // cycles since reference 0 last moved; saturates
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i || $changed(ref_clk_i[0]))
         quiet_q <= 8'h00;
      else if (quiet_q != 8'hff)
         quiet_q <= quiet_q + 8'h01;
   end

   sequence start_pulse_s;
      align_start_o ##1 !align_start_o;
   endsequence

   reset_values_a: assert property ($fell(sys_rst_i) |-> cfg_o == 17'h0_319f && align_enable_o)
      else $error("fields not at reset values");
   pin_types_a: assert property ($fell(sys_rst_i) |-> !lock_pin_oe_n_o && !holdover_pin_oe_n_o
      && status_pin0_oe_n_o && sync_pin_oe_n_o)
      else $error("pin drive state wrong after reset");
   start_pulse_a: assert property (align_start_o |-> start_pulse_s)
      else $error("start pulse longer than one cycle");
   start_enabled_a: assert property (align_start_o |-> align_enable_o)
      else $error("start while alignment disabled");
   hold_release_a: assert property (!align_enable_o || (loop1_lock_i && loop2_lock_i) |-> !align_hold_o)
      else $error("hold without cause");
   holdover_entry_a: assert property ($rose(holdover_active_o) |->
      !$past(loop1_lock_i) && $past(cfg_o.holdover_mode) == 2'h2)
      else $error("holdover entered without lock loss");
   holdover_mode_a: assert property (cfg_o.holdover_mode != 2'h2 |=> !holdover_active_o)
      else $error("holdover active outside automatic mode");
   loss_disable_a: assert property (!cfg_o.ref_input_usable[0] |=> !signal_loss_o[0])
      else $error("loss flagged on unusable input");
   loss_timing_a: assert property ($rose(signal_loss_o[0]) |-> quiet_q >= 8'h3a && quiet_q <= 8'h46)
      else $error("loss timeout out of range");
endmodule // sholdc_config_bank_checker

bind sholdc_config_bank sholdc_config_bank_checker i_sholdc_config_bank_checker (
   .core_clk_i, .sys_rst_i, .ref_clk_i, .loop1_lock_i, .loop2_lock_i, .cfg_o, .align_enable_o,
   .align_hold_o, .align_start_o, .holdover_active_o, .signal_loss_o, .sync_pin_oe_n_o,
   .lock_pin_oe_n_o, .holdover_pin_oe_n_o, .status_pin0_oe_n_o);

// ==== tb/sholdc_config_bank_test.sv ====
// self-checking bench for the configuration bank.
// assumes the host model owns the serial pins; all other inputs change on falling edges.
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; $display("ERROR %0t got %h want %h", $time, a, e); end end
module sholdc_config_bank_test;
   logic                    core_clk_i    = 1'b0;
   logic                    sys_rst_i     = 1'b1;
   logic                    ser_clk_i;
   logic                    ser_data_i;
   logic                    ser_latch_i;
   logic [2:0]              ref_clk_i     = 3'h0;
   logic [2:0]              ref_run       = 3'h7;
   logic [1:0]              ref_div       = 2'h0;
   logic                    loop1_lock_i  = 1'b1;
   logic                    loop2_lock_i  = 1'b1;
   logic                    sync_pin_i    = 1'b1;
   logic                    status_pin0_i = 1'b0;
   logic                    status_pin1_i = 1'b0;
   sholdc_pkg::sholdc_cfg_t cfg_o;
   logic                    align_enable_o, align_hold_o, align_start_o, holdover_active_o;
   logic [2:0]              signal_loss_o;
   logic [1:0]              ref_select_o;
   logic                    sync_pin_oe_n_o, lock_pin_o, lock_pin_oe_n_o, holdover_pin_o;
   logic                    holdover_pin_oe_n_o, status_pin0_oe_n_o, sync_pin_o, status_pin0_o, status_pin1_o;
   logic [31:0]             seed          = 32'h0000_0033;
   logic [31:0]             w [4]         = '{sholdc_pkg::RST_SYNC, sholdc_pkg::RST_LOCK,
                                              sholdc_pkg::RST_HOLD, sholdc_pkg::RST_LOS};
   int                      n_fail        = 0;
   int                      tests_run     = 0;
   int                      n_start       = 0;

   sholdc_host_model i_sholdc_host_model (.core_clk_i, .ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
      .ser_latch_o(ser_latch_i));
   sholdc_config_bank i_sholdc_config_bank (.core_clk_i, .sys_rst_i, .ser_clk_i, .ser_data_i, .ser_latch_i,
      .ref_clk_i, .loop1_lock_i, .loop2_lock_i, .sync_pin_i, .status_pin0_i, .status_pin1_i, .cfg_o,
      .align_enable_o, .align_hold_o, .align_start_o, .holdover_active_o, .signal_loss_o, .ref_select_o,
      .sync_pin_o, .sync_pin_oe_n_o, .lock_pin_o, .lock_pin_oe_n_o, .holdover_pin_o, .holdover_pin_oe_n_o,
      .status_pin0_o, .status_pin0_oe_n_o, .status_pin1_o, .status_pin1_oe_n_o());

   always #10 core_clk_i = ~core_clk_i;

   // references toggle every 4 cycles, well inside the shortest timeout
   always @(negedge core_clk_i)
   begin
      ref_div <= ref_div + 2'h1;
      if (ref_div == 2'h3)
         ref_clk_i <= ref_clk_i ^ ref_run;
   end

   always @(negedge core_clk_i)
      if (align_start_o === 1'b1)
         n_start++;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic sholdc_pkg::sholdc_cfg_t exp_cfg(input logic [31:0] s, l, h);
      sholdc_pkg::sholdc_cfg_t c;
      c.crystal_osc_enable    = s[5];
      c.align_qualify         = s[17];
      c.exclude_from_align    = s[25:20];
      c.holdover_track_enable = l[8];
      c.holdover_mode         = l[7:6];
      c.reference_select_mode = h[11:9];
      c.ref_input_usable      = h[7:5];
      return c;
   endfunction

   // pin level with both loops locked and no holdover, loss or hold
   function automatic logic exp_pin(input logic [2:0] code, input logic rb);
      return (code inside {3'h1, 3'h2, 3'h3}) | (code == 3'h7 && rb);
   endfunction

   task automatic idle(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask

   task automatic wr(input logic [31:0] word);
      i_sholdc_host_model.write_word(word);
      if (word[4:0] inside {[5'h0b:5'h0e]})
         w[word[4:0] - 5'h0b] = word;
      idle(2);
   endtask

   task automatic chk_regs();
      `CHK(cfg_o, exp_cfg(w[0], w[1], w[2]))
      `CHK(align_enable_o, w[0][26])
      `CHK(holdover_pin_oe_n_o, w[2][26:24] != 3'h3)
      `CHK(status_pin0_oe_n_o, w[2][18:16] != 3'h3)
   endtask

   task automatic complete_run();
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      repeat (100000) @(posedge core_clk_i);
      n_fail++;
      complete_run();
   end

   initial
   begin
      logic [31:0] r;
      logic [4:0]  a;
      int          n0;
      idle(8);
      sys_rst_i = 1'b0;
      idle(3);
      `CHK(n_start, 0)
      `CHK(cfg_o.exclude_from_align, 6'h18)
      chk_regs();
      `CHK(sync_pin_oe_n_o, 1'b1)
      // last write goes to an unmapped address: no register changes and readback reads zero
      for (int i = 0; i < 12; i++)
      begin
         r = xs();
         a = (i == 11) ? 5'h1f : 5'h0b + {3'h0, r[1:0]};
         wr({r[31:5], a});
         chk_regs();
         `CHK(status_pin0_o, exp_pin(w[2][14:12], (i < 11) & r[31]))
         `CHK(status_pin1_o, exp_pin(w[2][22:20], (i < 11) & r[31]))
         `CHK(sync_pin_o, exp_pin({1'b0, w[0][19:18]}, 1'b0))
      end
      wr(sholdc_pkg::RST_SYNC);
      wr(sholdc_pkg::RST_LOCK);
      wr(sholdc_pkg::RST_HOLD);
      wr(32'h9200_000e);
      `CHK(holdover_pin_o, 1'b1)
      wr(sholdc_pkg::RST_LOS);
      `CHK(holdover_pin_o, 1'b0)
      chk_regs();
      wr(32'h0581_900b);
      n0 = n_start;
      wr(32'h0000_0003);
      `CHK(n_start - n0, 1)
      wr(sholdc_pkg::RST_SYNC);
      n0 = n_start;
      wr(32'h0000_0003);
      `CHK(n_start - n0, 0)
      sync_pin_i = 1'b0;
      idle(8);
      `CHK(n_start - n0, 1)
      sync_pin_i = 1'b1;
      wr(32'h0580_100b);
      n0 = n_start;
      sync_pin_i = 1'b0;
      idle(8);
      sync_pin_i = 1'b1;
      idle(8);
      `CHK(n_start - n0, 1)
      wr(32'h0180_100b);
      n0 = n_start;
      sync_pin_i = 1'b0;
      idle(8);
      sync_pin_i = 1'b1;
      idle(8);
      `CHK(n_start - n0, 0)
      wr(sholdc_pkg::RST_SYNC);
      // alternate which loop is missing so each hold bit is tried both ways
      for (int i = 0; i < 4; i++)
      begin
         if (!i[0])
            wr(i[1] ? 32'h1b40_018c : 32'h1b80_018c);
         loop1_lock_i = i[0] ~^ i[1];
         loop2_lock_i = ~(i[0] ~^ i[1]);
         idle(3);
         `CHK(align_hold_o, ~i[0])
         `CHK(lock_pin_o, 1'b0)
      end
      loop1_lock_i = 1'b1;
      loop2_lock_i = 1'b1;
      idle(3);
      `CHK(lock_pin_o, 1'b1)
      wr(sholdc_pkg::RST_LOCK);
      loop1_lock_i = 1'b0;
      idle(4);
      `CHK(holdover_active_o, 1'b1)
      loop1_lock_i = 1'b1;
      idle(4);
      `CHK(holdover_active_o, 1'b0)
      wr(32'h3b02_86ed);
      loop1_lock_i = 1'b0;
      idle(4);
      `CHK(holdover_active_o, 1'b0)
      loop1_lock_i = 1'b1;
      status_pin0_i = 1'b1;
      wr(sholdc_pkg::RST_HOLD);
      `CHK(ref_select_o, 2'h1)
      wr(32'h3b02_07ed);
      `CHK(ref_select_o, 2'h2)
      wr(sholdc_pkg::RST_HOLD);
      ref_run = 3'h6;
      idle(50);
      `CHK(signal_loss_o, 3'h0)
      idle(20);
      `CHK(signal_loss_o, 3'h1)
      wr(32'h0200_000e);
      `CHK(signal_loss_o, 3'h0)
      ref_run = 3'h7;
      wr(sholdc_pkg::RST_LOS);
      complete_run();
   end
endmodule // sholdc_config_bank_test
